/* hdl/rail_pressure_pkg.sv */
// Constants and carrier types for the rail pressure sensor monitor.
package rail_pressure_pkg;
   // Clock and time base; timers below count time-base ticks of 1 ms.
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 17;
   localparam int TICK_PERIOD_MS = 1;
   // Voltage checks, millivolts, and their persistence time.
   localparam logic [15:0] LOW_MV = 16'h0064;
   localparam logic [15:0] HIGH_MV = 16'h1324;
   localparam int VOLT_TIME_MS = 500;
   localparam logic [9:0] VOLT_TICKS = 10'(VOLT_TIME_MS / TICK_PERIOD_MS);
   // Stuck check: duty in tenths of a percent, pressure in kPa.
   localparam logic [10:0] DUTY_INT_LIMIT = 11'h028;
   localparam logic [15:0] STUCK_SPREAD_KPA = 16'h0005;
   // Offset check thresholds and times.
   localparam logic [15:0] OFFSET_ERR_KPA = 16'h001E;
   localparam int SETTLE_TIME_MS = 5000;
   localparam int NORMAL_TIME_MS = 1000;
   localparam int FAIL_TIME_MS = 5000;
   localparam logic [12:0] SETTLE_TICKS = 13'(SETTLE_TIME_MS / TICK_PERIOD_MS);
   localparam logic [12:0] NORMAL_TICKS = 13'(NORMAL_TIME_MS / TICK_PERIOD_MS);
   localparam logic [12:0] FAIL_TICKS = 13'(FAIL_TIME_MS / TICK_PERIOD_MS);
   // Enabling fuel level, percent.
   localparam logic [7:0] FUEL_MIN_PCT = 8'h0B;
   // Stored fault codes.
   localparam logic [15:0] CODE_LOW = 16'h0192;
   localparam logic [15:0] CODE_HIGH = 16'h0193;
   localparam logic [15:0] CODE_STUCK = 16'h0191;
   localparam logic [15:0] CODE_OFFSET = 16'h0190;
   // Register byte offsets.
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_MASK = 8'h04;
   localparam logic [7:0] REG_FAULT = 8'h08;
   localparam logic [7:0] REG_CODE = 8'h0C;
   localparam logic [7:0] REG_LIVE = 8'h10;
   // Event bit positions, shared by status and mask.
   localparam int EV_LOW_FAIL = 0;
   localparam int EV_HIGH_FAIL = 1;
   localparam int EV_STUCK_FAIL = 2;
   localparam int EV_STUCK_PASS = 3;
   localparam int EV_OFFSET_FAIL = 4;
   localparam int EV_OFFSET_PASS = 5;
   // Stored fault bit positions.
   localparam int FLT_LOW = 0;
   localparam int FLT_HIGH = 1;
   localparam int FLT_STUCK = 2;
   localparam int FLT_OFFSET = 3;
   // Reset values.
   localparam logic [5:0] MASK_RESET = 6'h00;
   // Stuck window minimum starts at full scale so any sample replaces it.
   localparam logic [15:0] STK_MIN_RESET = 16'hFFFF;

   // Sampled engine conditions, all produced on hclk.
   typedef struct packed {
      logic ignition;
      logic closed_loop;
      logic idle;
      logic [7:0] fuel_pct;
      logic [15:0] volt_mv;
      logic [15:0] press_kpa;
      logic [15:0] target_kpa;
      logic [9:0] duty_pm;
   } sense_s;
endpackage

/* hdl/rail_pressure_sensor_monitor.sv */
// Rail pressure sensor monitor: range, stuck and offset checks, AHB-Lite.
//
// Added by the designer: register access over AHB-Lite and the register offsets.
module rail_pressure_sensor_monitor #(
   parameter int unsigned TICK_CYCLES = rail_pressure_pkg::TICK_CYCLES
)(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire rail_pressure_pkg::sense_s sense,
   output logic irq,
   output logic [3:0] fault_flags
);

   typedef struct packed {
      logic [rail_pressure_pkg::TICK_W-1:0] tick_cnt;
      logic [9:0] low_ms;
      logic [9:0] high_ms;
      logic [15:0] stk_max;
      logic [15:0] stk_min;
      logic [10:0] stk_int;
      logic [9:0] prev_duty;
      logic [12:0] settle_ms;
      logic [12:0] norm_ms;
      logic [12:0] fail_ms;
      logic [5:0] status;
      logic [5:0] mask;
      logic [3:0] faults;
      logic [15:0] last_code;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic ready;
      logic irq;
   } state_s;

   state_s q_ff;
   state_s nxt_q;

   logic tick;
   logic fuel_ok;
   logic stk_en;
   logic off_en;
   logic settled;
   logic [15:0] spread;
   logic [15:0] off_err;
   logic [9:0] duty_step;
   logic [15:0] new_max;
   logic [15:0] new_min;
   logic [11:0] int_sum;
   logic [5:0] ev;
   logic [5:0] st_clr;
   logic [3:0] flt_clr;
   logic addr_ok;

   assign hrdata = q_ff.rdata;
   assign hreadyout = q_ff.ready;
   assign hresp = 1'b0;
   assign irq = q_ff.irq;
   assign fault_flags = q_ff.faults;

   // Enabling conditions and arithmetic shared by the checks.
   always_comb
   begin
      tick = q_ff.tick_cnt ==
         rail_pressure_pkg::TICK_W'(TICK_CYCLES - 1);
      fuel_ok = sense.fuel_pct >= rail_pressure_pkg::FUEL_MIN_PCT;
      stk_en = sense.ignition & sense.closed_loop & fuel_ok;
      off_en = sense.ignition & sense.idle & sense.closed_loop & fuel_ok;
      settled = q_ff.settle_ms > rail_pressure_pkg::SETTLE_TICKS;
      duty_step = (sense.duty_pm >= q_ff.prev_duty) ?
         sense.duty_pm - q_ff.prev_duty : q_ff.prev_duty - sense.duty_pm;
      new_max = (sense.press_kpa > q_ff.stk_max) ?
         sense.press_kpa : q_ff.stk_max;
      new_min = (sense.press_kpa < q_ff.stk_min) ?
         sense.press_kpa : q_ff.stk_min;
      spread = new_max - new_min;
      int_sum = {1'b0, q_ff.stk_int} + {2'b00, duty_step};
      off_err = (sense.target_kpa >= sense.press_kpa) ?
         sense.target_kpa - sense.press_kpa :
         sense.press_kpa - sense.target_kpa;
   end

   // Next state: time base, the three checks, events and the bus slave.
   always_comb
   begin
      nxt_q = q_ff;
      ev = 6'h00;
      st_clr = 6'h00;
      flt_clr = 4'h0;
      addr_ok = 1'b0;
      nxt_q.tick_cnt = tick ? '0 : q_ff.tick_cnt + 1'b1;

      if (!sense.ignition)
      begin
         nxt_q.low_ms = 10'h000;
         nxt_q.high_ms = 10'h000;
      end
      else if (tick)
      begin
         if (sense.volt_mv <= rail_pressure_pkg::LOW_MV)
         begin
            if (q_ff.low_ms <= rail_pressure_pkg::VOLT_TICKS)
            begin
               nxt_q.low_ms = q_ff.low_ms + 1'b1;
               ev[rail_pressure_pkg::EV_LOW_FAIL] =
                  q_ff.low_ms == rail_pressure_pkg::VOLT_TICKS;
            end
         end
         else
         begin
            nxt_q.low_ms = 10'h000;
         end
         if (sense.volt_mv >= rail_pressure_pkg::HIGH_MV)
         begin
            if (q_ff.high_ms <= rail_pressure_pkg::VOLT_TICKS)
            begin
               nxt_q.high_ms = q_ff.high_ms + 1'b1;
               ev[rail_pressure_pkg::EV_HIGH_FAIL] =
                  q_ff.high_ms == rail_pressure_pkg::VOLT_TICKS;
            end
         end
         else
         begin
            nxt_q.high_ms = 10'h000;
         end
      end

      // Stuck check, one evaluation step per tick.
      if (tick)
      begin
         nxt_q.prev_duty = sense.duty_pm;
         if (!stk_en)
         begin
            nxt_q.stk_int = 11'h000;
            nxt_q.stk_max = sense.press_kpa;
            nxt_q.stk_min = sense.press_kpa;
         end
         else if (int_sum >= {1'b0, rail_pressure_pkg::DUTY_INT_LIMIT})
         begin
            if (spread < rail_pressure_pkg::STUCK_SPREAD_KPA)
               ev[rail_pressure_pkg::EV_STUCK_FAIL] = 1'b1;
            else
               ev[rail_pressure_pkg::EV_STUCK_PASS] = 1'b1;
            nxt_q.stk_int = 11'h000;
            nxt_q.stk_max = sense.press_kpa;
            nxt_q.stk_min = sense.press_kpa;
         end
         else
         begin
            nxt_q.stk_int = int_sum[10:0];
            nxt_q.stk_max = new_max;
            nxt_q.stk_min = new_min;
         end
      end

      // Offset check: settle in closed loop, then compare at idle.
      if (!sense.closed_loop || !sense.ignition)
      begin
         nxt_q.settle_ms = 13'h0000;
      end
      else if (tick && !settled)
      begin
         nxt_q.settle_ms = q_ff.settle_ms + 1'b1;
      end
      if (!off_en || !settled)
      begin
         nxt_q.norm_ms = 13'h0000;
         nxt_q.fail_ms = 13'h0000;
      end
      else if (tick)
      begin
         if (off_err < rail_pressure_pkg::OFFSET_ERR_KPA)
         begin
            nxt_q.fail_ms = 13'h0000;
            nxt_q.norm_ms = q_ff.norm_ms + 1'b1;
            if (q_ff.norm_ms + 1'b1 == rail_pressure_pkg::NORMAL_TICKS)
            begin
               ev[rail_pressure_pkg::EV_OFFSET_PASS] = 1'b1;
               nxt_q.norm_ms = 13'h0000;
            end
         end
         else
         begin
            nxt_q.norm_ms = 13'h0000;
            nxt_q.fail_ms = q_ff.fail_ms + 1'b1;
            if (q_ff.fail_ms + 1'b1 == rail_pressure_pkg::FAIL_TICKS)
            begin
               ev[rail_pressure_pkg::EV_OFFSET_FAIL] = 1'b1;
               nxt_q.fail_ms = 13'h0000;
            end
         end
      end

      // Data phase of a write: the word lands one edge after the address.
      nxt_q.wr_pend = 1'b0;
      if (q_ff.wr_pend)
      begin
         unique case (q_ff.wr_addr)
            rail_pressure_pkg::REG_STATUS: st_clr = hwdata[5:0];
            rail_pressure_pkg::REG_MASK: nxt_q.mask = hwdata[5:0];
            rail_pressure_pkg::REG_FAULT: flt_clr = hwdata[3:0];
            default: st_clr = 6'h00;
         endcase
      end

      // Sticky flags: a new event beats a clear written in the same cycle.
      nxt_q.status = (q_ff.status & ~st_clr) | ev;
      nxt_q.faults = (q_ff.faults & ~flt_clr) |
         {ev[rail_pressure_pkg::EV_OFFSET_FAIL],
          ev[rail_pressure_pkg::EV_STUCK_FAIL],
          ev[rail_pressure_pkg::EV_HIGH_FAIL],
          ev[rail_pressure_pkg::EV_LOW_FAIL]};
      if (ev[rail_pressure_pkg::EV_LOW_FAIL])
         nxt_q.last_code = rail_pressure_pkg::CODE_LOW;
      if (ev[rail_pressure_pkg::EV_HIGH_FAIL])
         nxt_q.last_code = rail_pressure_pkg::CODE_HIGH;
      if (ev[rail_pressure_pkg::EV_STUCK_FAIL])
         nxt_q.last_code = rail_pressure_pkg::CODE_STUCK;
      if (ev[rail_pressure_pkg::EV_OFFSET_FAIL])
         nxt_q.last_code = rail_pressure_pkg::CODE_OFFSET;
      nxt_q.irq = |(nxt_q.status & nxt_q.mask);

      // Address phase: latch writes, prepare read data for the data phase.
      nxt_q.ready = 1'b1;
      if (hsel && htrans[1] && hready)
      begin
         addr_ok = haddr[31:8] == 24'h000000;
         nxt_q.wr_pend = hwrite & addr_ok;
         nxt_q.wr_addr = haddr[7:0];
         nxt_q.rdata = 32'h00000000;
         if (!hwrite && addr_ok)
         begin
            unique case (haddr[7:0])
               rail_pressure_pkg::REG_STATUS:
                  nxt_q.rdata = {26'h0000000, q_ff.status};
               rail_pressure_pkg::REG_MASK:
                  nxt_q.rdata = {26'h0000000, q_ff.mask};
               rail_pressure_pkg::REG_FAULT:
                  nxt_q.rdata = {28'h0000000, q_ff.faults};
               rail_pressure_pkg::REG_CODE:
                  nxt_q.rdata = {16'h0000, q_ff.last_code};
               rail_pressure_pkg::REG_LIVE:
                  nxt_q.rdata = {29'h00000000, settled, off_en, stk_en};
               default: nxt_q.rdata = 32'h00000000;
            endcase
         end
      end
   end

   // One register bank for the whole block; the hsize of a transfer is
   // not checked because only whole-word accesses are expected.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q_ff <= '0;
         q_ff.mask <= rail_pressure_pkg::MASK_RESET;
         q_ff.stk_min <= rail_pressure_pkg::STK_MIN_RESET; // No false spread.
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

endmodule

/* tb/rail_pressure_checker.sv */
// Port-level assertions for the rail pressure sensor monitor.
module rail_pressure_checker #(
   parameter int unsigned TICK_CYCLES = rail_pressure_pkg::TICK_CYCLES
)(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire rail_pressure_pkg::sense_s sense,
   input wire logic irq,
   input wire logic [3:0] fault_flags
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_ff;
   logic far_ff;
   int run_ff;
   logic low;
   logic big;
   logic [15:0] dif;
   // Offset error of either sign and the low-voltage condition.
   assign dif = sense.target_kpa > sense.press_kpa ?
      sense.target_kpa - sense.press_kpa : sense.press_kpa - sense.target_kpa;
   assign big = dif >= rail_pressure_pkg::OFFSET_ERR_KPA;
   assign low = sense.ignition && sense.volt_mv <= rail_pressure_pkg::LOW_MV;
   // Write data phases, unmapped reads and the length of a low run in clocks.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ff <= 1'b0;
         far_ff <= 1'b0;
         run_ff <= 0;
      end
      else
      begin
         wr_ff <= hsel && htrans[1] && hready && hwrite;
         far_ff <= hsel && htrans[1] && hready && !hwrite && |haddr[31:8];
         run_ff <= low ? run_ff + 1 : 0;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   property p_ign;
      $rose(|fault_flags[1:0]) |-> $past(sense.ignition);
   endproperty
   a_ign: assert property (p_ign)
      else $error("range flag without ignition");
   property p_low;
      $rose(fault_flags[0]) |-> run_ff >= 500 * TICK_CYCLES;
   endproperty
   a_low: assert property (p_low)
      else $error("low flag too early");
   property p_high;
      $rose(fault_flags[1]) |-> $past(sense.volt_mv) >= 16'h1324;
   endproperty
   a_high: assert property (p_high)
      else $error("high flag below threshold");
   property p_stuck;
      $rose(fault_flags[2]) |-> $past(sense.closed_loop) &&
         $past(sense.fuel_pct) >= 8'h0B;
   endproperty
   a_stuck: assert property (p_stuck)
      else $error("stuck flag while disabled");
   property p_offset;
      $rose(fault_flags[3]) |-> $past(sense.idle) && $past(big);
   endproperty
   a_offset: assert property (p_offset)
      else $error("offset flag without idle error");
   property p_hold;
      |($past(fault_flags) & ~fault_flags) |-> $past(wr_ff);
   endproperty
   a_hold: assert property (p_hold)
      else $error("fault flag lost without write");
   property p_irq;
      $fell(irq) && $past(hresetn) |-> $past(wr_ff);
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq dropped without write");
   property p_far;
      far_ff |-> hrdata == 32'h00000000;
   endproperty
   a_far: assert property (p_far)
      else $error("unmapped read not zero");
endmodule

bind rail_pressure_sensor_monitor rail_pressure_checker #(
   .TICK_CYCLES(TICK_CYCLES)
) u_rail_pressure_checker (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .sense(sense), .irq(irq), .fault_flags(fault_flags)
);

/* tb/rail_pressure_sensor_monitor_bench.sv */
// Self-checking bench for the rail pressure sensor monitor.
module rail_pressure_sensor_monitor_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 5;
   typedef struct packed {
      rail_pressure_pkg::sense_s cfg;
      logic [9:0] ds;
      logic [15:0] ps;
      int ticks;
      logic [5:0] st;
      logic [3:0] fl;
      logic [15:0] cd;
   } row_s;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   rail_pressure_pkg::sense_s cfg = '0;
   rail_pressure_pkg::sense_s sense;
   logic [9:0] ds = 10'h0;
   logic [15:0] ps = 16'h0;
   logic irq;
   logic [3:0] fault_flags;
   logic [31:0] rd;
   int n_errors = 0;
   int n_tests = 0;
   // Levels, swings, ticks to run and the registers expected afterwards.
   row_s rows [6] = '{
      '{'{1'b0,1'b0,1'b0,8'h0B,16'h0032,16'h0,16'h0,10'h0},10'h0,16'h0,
        502,6'h00,4'h0,16'h0000},
      '{'{1'b1,1'b0,1'b0,8'h0B,16'h0064,16'h0,16'h0,10'h0},10'h0,16'h0,
        502,6'h01,4'h1,16'h0192},
      '{'{1'b1,1'b0,1'b0,8'h0B,16'h1324,16'h0,16'h0,10'h0},10'h0,16'h0,
        502,6'h02,4'h2,16'h0193},
      '{'{1'b1,1'b1,1'b0,8'h0B,16'h09C4,16'h0,16'h0,10'h0},10'h00A,16'h0,
        20,6'h04,4'h4,16'h0191},
      '{'{1'b1,1'b1,1'b0,8'h0B,16'h09C4,16'h0,16'h0,10'h0},10'h00A,16'h5,
        20,6'h08,4'h0,16'h0000},
      '{'{1'b1,1'b1,1'b1,8'h0B,16'h09C4,16'h12C,16'h149,10'h0},10'h0,16'h0,
        6003,6'h20,4'h0,16'h0000}};
   assign hready = hreadyout;
   rail_pressure_sensor_monitor #(
      .TICK_CYCLES(TC)
   ) u_rail_pressure_sensor_monitor (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sense(sense), .irq(irq), .fault_flags(fault_flags)
   );
   rail_sensor_model u_rail_sensor_model (
      .hclk(hclk), .hresetn(hresetn), .cfg(cfg), .ds(ds), .ps(ps),
      .sense(sense)
   );
   // Free-running 125 MHz clock.
   initial
   begin
      forever #4 hclk = ~hclk;
   end
   task automatic complete_run;
      if (n_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask
   // Bounded wait for hready at a rising edge; a hang ends the run.
   task automatic rdy;
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         n_errors++;
         complete_run;
      end
   endtask
   // One single word transfer; bit 8 of the address selects unmapped space.
   task automatic bus(input logic w, input logic [8:0] a,
      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {23'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy;
      r = hrdata;
   endtask
   task automatic start(input row_s r);
      hresetn <= 1'b0;
      cfg <= r.cfg;
      ds <= r.ds;
      ps <= r.ps;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
   endtask
   task automatic regs(input row_s r);
      bus(1'b0, 9'h000, 32'h0, rd);
      chk("status", {26'h0, r.st}, rd);
      bus(1'b0, 9'h008, 32'h0, rd);
      chk("fault", {28'h0, r.fl}, rd);
      bus(1'b0, 9'h00C, 32'h0, rd);
      chk("code", {16'h0, r.cd}, rd);
      chk("flags", {28'h0, r.fl}, {28'h0, fault_flags});
   endtask
   // Table rows first, then the offset failure, interrupt and boundaries.
   initial
   begin
      for (int i = 0; i < 6; i++)
      begin
         start(rows[i]);
         repeat (rows[i].ticks * TC) @(posedge hclk);
         regs(rows[i]);
      end
      cfg.target_kpa <= 16'h014A;
      repeat (5001 * TC) @(posedge hclk);
      chk("offset", 32'h8, {28'h0, fault_flags});
      bus(1'b0, 9'h00C, 32'h0, rd);
      chk("ocode", {16'h0, rail_pressure_pkg::CODE_OFFSET}, rd);
      bus(1'b0, 9'h010, 32'h0, rd);
      chk("live", 32'h7, rd);
      cfg.fuel_pct <= 8'h0A;
      bus(1'b0, 9'h010, 32'h0, rd);
      chk("live fuel", 32'h4, rd);
      chk("irq off", 32'h0, {31'h0, irq});
      bus(1'b1, 9'h004, 32'h10, rd);
      repeat (2) @(posedge hclk);
      chk("irq on", 32'h1, {31'h0, irq});
      bus(1'b1, 9'h000, 32'h10, rd);
      repeat (2) @(posedge hclk);
      chk("irq clr", 32'h0, {31'h0, irq});
      bus(1'b0, 9'h000, 32'h0, rd);
      chk("w1c", 32'h20, rd);
      bus(1'b1, 9'h008, 32'hF, rd);
      bus(1'b1, 9'h100, 32'hFFFFFFFF, rd);
      bus(1'b0, 9'h100, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      bus(1'b0, 9'h004, 32'h0, rd);
      chk("mask", 32'h10, rd);
      chk("fclr", 32'h0, {28'h0, fault_flags});
      start(rows[1]);
      repeat (400 * TC) @(posedge hclk);
      cfg.ignition <= 1'b0;
      @(posedge hclk);
      cfg.ignition <= 1'b1;
      repeat (501 * TC - 2) @(posedge hclk);
      #1;
      chk("low early", 32'h0, {28'h0, fault_flags});
      @(posedge hclk);
      #1;
      chk("low due", 32'h1, {28'h0, fault_flags});
      complete_run;
   end
endmodule

/* tb/rail_sensor_model.sv */
// Behavioural pressure sensor and pump control that feed the monitor.
module rail_sensor_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire rail_pressure_pkg::sense_s cfg,
   input wire logic [9:0] ds,
   input wire logic [15:0] ps,
   output rail_pressure_pkg::sense_s sense
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ph_ff;
   // Phase flips each clock; with an odd tick length every tick sees the
   // other phase, so duty and pressure really move between samples.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ph_ff <= 1'b0;
      else
         ph_ff <= ~ph_ff;
   end
   // Steady levels from the bench with the swing added in one phase.
   always_comb
   begin
      sense = cfg;
      sense.duty_pm = cfg.duty_pm + (ph_ff ? ds : 10'h000);
      sense.press_kpa = cfg.press_kpa + (ph_ff ? ps : 16'h0000);
   end
endmodule
